/* hw/cvcfg_defs.svh */
// Offsets, field positions, reset values and constants of the converter config bank
`ifndef CVCFG_DEFS_SVH
`define CVCFG_DEFS_SVH

// ==========================================
// Register offsets
`define CVCFG_OFS_CCD_CFG 8'hd8
`define CVCFG_OFS_IOV_THR 8'hda

// ==========================================
// Reset values and the value read at unmapped offsets
`define CVCFG_RST_CCD_CFG 8'h8b
`define CVCFG_RST_IOV_THR 8'hff
`define CVCFG_RD_UNMAPPED 8'h00

// ==========================================
// Field positions in the compensation and driver byte
`define CVCFG_FB_DIV_BIT 7
`define CVCFG_CDC_EN_BIT 6
`define CVCFG_CABLE_DROP_COMP_GAIN_HI 5
`define CVCFG_CABLE_DROP_COMP_GAIN_LO 4
`define CVCFG_DRV_SEQ_HI 3
`define CVCFG_DRV_SEQ_LO 2
`define CVCFG_DRV_SUP_HI 1
`define CVCFG_DRV_SUP_LO 0

// ==========================================
// Threshold code to millivolt mapping
`define CVCFG_THR_SEG_LAST 8'h94
`define CVCFG_THR_SEG2_FIRST 8'h95
`define CVCFG_THR_BASE_MV 16'h128e
`define CVCFG_THR_STEP1_MV 16'h007d
`define CVCFG_THR_SEG2_MV 16'h5bcc
`define CVCFG_THR_STEP2_MV 16'h00fa

// ==========================================
// Serial interface
`define CVCFG_I2C_ADDR 7'h30
`define CVCFG_BITS_PER_BYTE 4'h8

`endif

/* hw/cvcfg_pkg.sv */
// Types shared by the converter config bank modules
package cvcfg_pkg;

	// ==========================================
	// Serial protocol states
	typedef enum logic [3:0] {
		CVCFG_IDLE,
		CVCFG_ADDR,
		CVCFG_ACK_ADDR,
		CVCFG_PTR,
		CVCFG_ACK_PTR,
		CVCFG_WDATA,
		CVCFG_ACK_WDATA,
		CVCFG_RDATA,
		CVCFG_RACK
	} cvcfg_fsm_t;

	// ==========================================
	// Pin conditioner state
	typedef struct packed {
		logic [2:0] scl_ff;
		logic [2:0] sda_ff;
		logic scl_lvl;
		logic sda_lvl;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
	} cvcfg_sync_t;

	// ==========================================
	// Register bank state
	typedef struct packed {
		cvcfg_fsm_t state;
		logic [7:0] sh;
		logic [3:0] cnt;
		logic rw;
		logic nack;
		logic [7:0] ptr;
		logic [7:0] cfg;
		logic [7:0] thr;
		logic [15:0] thr_mv;
		logic prot;
		logic regul;
		logic sda_oe;
	} cvcfg_state_t;

endpackage : cvcfg_pkg

/* hw/cvcfg_pin_if.sv */
// Conditioned serial pin levels and events between conditioner and bank
interface cvcfg_pin_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;

	// Conditioner drives, bank reads
	modport src (output scl, sda, scl_rise, scl_fall, start, stop);
	modport snk (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface : cvcfg_pin_if

/* hw/cvcfg_pin_sync.sv */
// Three-stage pin conditioner with start and stop detection
`include "cvcfg_defs.svh"

module cvcfg_pin_sync (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Raw pins
	input wire logic scl_i,
	input wire logic sda_i,
	// Conditioned levels and events
	cvcfg_pin_if.src pin
);
	import cvcfg_pkg::*;

	cvcfg_sync_t s_q;
	cvcfg_sync_t s_d;

	// ==========================================
	// Next state: level accepted once stages two and three agree
	always_comb begin
		s_d = s_q;
		s_d.scl_ff = {s_q.scl_ff[1:0], scl_i};
		s_d.sda_ff = {s_q.sda_ff[1:0], sda_i};
		if (s_q.scl_ff[1] == s_q.scl_ff[2]) begin
			s_d.scl_lvl = s_q.scl_ff[1];
		end
		if (s_q.sda_ff[1] == s_q.sda_ff[2]) begin
			s_d.sda_lvl = s_q.sda_ff[1];
		end
		s_d.scl_rise = ~s_q.scl_lvl & s_d.scl_lvl;
		s_d.scl_fall = s_q.scl_lvl & ~s_d.scl_lvl;
		s_d.start = s_q.scl_lvl & s_d.scl_lvl & s_q.sda_lvl & ~s_d.sda_lvl;
		s_d.stop = s_q.scl_lvl & s_d.scl_lvl & ~s_q.sda_lvl & s_d.sda_lvl;
	end

	// ==========================================
	// State register, bus idles high
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '{scl_ff: 3'h7, sda_ff: 3'h7, scl_lvl: 1'b1, sda_lvl: 1'b1, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign pin.scl = s_q.scl_lvl;
	assign pin.sda = s_q.sda_lvl;
	assign pin.scl_rise = s_q.scl_rise;
	assign pin.scl_fall = s_q.scl_fall;
	assign pin.start = s_q.start;
	assign pin.stop = s_q.stop;

endmodule : cvcfg_pin_sync

/* hw/cvcfg_top.sv */
// Converter compensation, driver and input threshold registers behind a serial slave
`include "cvcfg_defs.svh"

module cvcfg_top (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Serial pins, data is open drain
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// Threshold function select
	input wire logic input_regulation_select_i,
	// Configuration outputs
	output logic fb_div_select_o,
	output logic cable_drop_comp_enable_o,
	output logic [1:0] cable_drop_comp_gain_o,
	output logic [1:0] fet_driver_sequencing_o,
	output logic [1:0] fet_driver_supply_select_o,
	output logic [7:0] input_threshold_code_o,
	output logic [15:0] input_threshold_mv_o,
	output logic protect_active_o,
	output logic regulate_active_o
);
	import cvcfg_pkg::*;

	cvcfg_pin_if pin ();
	cvcfg_state_t s_q;
	cvcfg_state_t s_d;
	logic [7:0] rd_byte;

	// ==========================================
	// Pin conditioning
	cvcfg_pin_sync u_sync (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.pin(pin)
	);

	// ==========================================
	// Helpers
	// Threshold code to millivolts
	function automatic logic [15:0] code_to_mv(input logic [7:0] code);
		logic [15:0] c;
		c = {8'h00, code};
		if (code <= `CVCFG_THR_SEG_LAST) begin
			code_to_mv = `CVCFG_THR_BASE_MV + c * `CVCFG_THR_STEP1_MV;
		end else begin
			code_to_mv = `CVCFG_THR_SEG2_MV +
				(c - {8'h00, `CVCFG_THR_SEG2_FIRST}) * `CVCFG_THR_STEP2_MV;
		end
	endfunction : code_to_mv

	// Readback mux, unmapped offsets read zero
	always_comb begin
		case (s_q.ptr)
			`CVCFG_OFS_CCD_CFG: rd_byte = s_q.cfg;
			`CVCFG_OFS_IOV_THR: rd_byte = s_q.thr;
			default: rd_byte = `CVCFG_RD_UNMAPPED;
		endcase
	end

	// ==========================================
	// Protocol and register next state
	// A stop or start overrides every state, so a cut frame
	// always returns the slave to a known place. The pointer
	// persists across frames and is never incremented, so
	// extra data bytes land on the same register again.
	always_comb begin
		s_d = s_q;
		s_d.thr_mv = code_to_mv(s_q.thr);
		s_d.prot = ~input_regulation_select_i;
		s_d.regul = input_regulation_select_i;
		if (pin.stop) begin
			s_d.state = CVCFG_IDLE;
			s_d.sda_oe = 1'b0;
		end else if (pin.start) begin
			s_d.state = CVCFG_ADDR;
			s_d.cnt = 4'h0;
			s_d.sda_oe = 1'b0;
		end else begin
			case (s_q.state)
				CVCFG_IDLE: begin
					s_d.sda_oe = 1'b0;
				end
				CVCFG_ADDR, CVCFG_PTR, CVCFG_WDATA: begin
					// Shift in on rise, act after eighth bit on fall
					if (pin.scl_rise) begin
						s_d.sh = {s_q.sh[6:0], pin.sda};
						s_d.cnt = s_q.cnt + 4'h1;
					end
					if (pin.scl_fall && s_q.cnt == `CVCFG_BITS_PER_BYTE) begin
						s_d.cnt = 4'h0;
						s_d.sda_oe = 1'b1;
						if (s_q.state == CVCFG_ADDR) begin
							if (s_q.sh[7:1] == `CVCFG_I2C_ADDR) begin
								s_d.rw = s_q.sh[0];
								s_d.state = CVCFG_ACK_ADDR;
							end else begin
								s_d.sda_oe = 1'b0;
								s_d.state = CVCFG_IDLE;
							end
						end else if (s_q.state == CVCFG_PTR) begin
							s_d.ptr = s_q.sh;
							s_d.state = CVCFG_ACK_PTR;
						end else begin
							// Whole-byte write to the addressed register
							if (s_q.ptr == `CVCFG_OFS_CCD_CFG) begin
								s_d.cfg = s_q.sh;
							end else if (s_q.ptr == `CVCFG_OFS_IOV_THR) begin
								s_d.thr = s_q.sh;
							end
							s_d.state = CVCFG_ACK_WDATA;
						end
					end
				end
				CVCFG_ACK_ADDR: begin
					// Read frames preload the addressed byte and drive bit seven
					if (pin.scl_fall) begin
						if (s_q.rw) begin
							s_d.sh = rd_byte;
							s_d.sda_oe = ~rd_byte[7];
							s_d.cnt = 4'h1;
							s_d.state = CVCFG_RDATA;
						end else begin
							s_d.sda_oe = 1'b0;
							s_d.state = CVCFG_PTR;
						end
					end
				end
				CVCFG_ACK_PTR, CVCFG_ACK_WDATA: begin
					if (pin.scl_fall) begin
						s_d.sda_oe = 1'b0;
						s_d.state = CVCFG_WDATA;
					end
				end
				CVCFG_RDATA: begin
					// Shift out on fall, release for master acknowledge
					if (pin.scl_fall) begin
						if (s_q.cnt == `CVCFG_BITS_PER_BYTE) begin
							s_d.sda_oe = 1'b0;
							s_d.cnt = 4'h0;
							s_d.state = CVCFG_RACK;
						end else begin
							s_d.sda_oe = ~s_q.sh[6];
							s_d.sh = {s_q.sh[6:0], 1'b0};
							s_d.cnt = s_q.cnt + 4'h1;
						end
					end
				end
				CVCFG_RACK: begin
					// Master acknowledge rereads the same register, nack ends it
					if (pin.scl_rise) begin
						s_d.nack = pin.sda;
					end
					if (pin.scl_fall) begin
						if (s_q.nack) begin
							s_d.state = CVCFG_IDLE;
						end else begin
							s_d.sh = rd_byte;
							s_d.sda_oe = ~rd_byte[7];
							s_d.cnt = 4'h1;
							s_d.state = CVCFG_RDATA;
						end
					end
				end
				default: begin
					s_d.state = CVCFG_IDLE;
					s_d.sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ==========================================
	// State register with documented reset values
	// The millivolt view is seeded from the threshold reset
	// code so that it agrees with the code from the first cycle.
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			s_q <= '{state: CVCFG_IDLE,
				cfg: `CVCFG_RST_CCD_CFG,
				thr: `CVCFG_RST_IOV_THR,
				thr_mv: code_to_mv(`CVCFG_RST_IOV_THR),
				prot: 1'b1,
				default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// Outputs straight from the state register
	// The data pin is open drain: the enable is the only
	// live control, the driven level is always low.
	assign sda_o = 1'b0; // Open drain, only low is driven
	assign sda_oe_o = s_q.sda_oe;
	assign fb_div_select_o = s_q.cfg[`CVCFG_FB_DIV_BIT];
	assign cable_drop_comp_enable_o = s_q.cfg[`CVCFG_CDC_EN_BIT];
	assign cable_drop_comp_gain_o = s_q.cfg[`CVCFG_CABLE_DROP_COMP_GAIN_HI:`CVCFG_CABLE_DROP_COMP_GAIN_LO];
	assign fet_driver_sequencing_o = s_q.cfg[`CVCFG_DRV_SEQ_HI:`CVCFG_DRV_SEQ_LO];
	assign fet_driver_supply_select_o = s_q.cfg[`CVCFG_DRV_SUP_HI:`CVCFG_DRV_SUP_LO];
	assign input_threshold_code_o = s_q.thr;
	assign input_threshold_mv_o = s_q.thr_mv;
	assign protect_active_o = s_q.prot;
	assign regulate_active_o = s_q.regul;

endmodule : cvcfg_top

/* dv/cvcfg_assertions.sv */
// Port checks for the converter config bank
module cvcfg_assertions (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Serial pins and select
	input wire logic scl_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic input_regulation_select_i,
	// Configuration outputs
	input wire logic fb_div_select_o,
	input wire logic cable_drop_comp_enable_o,
	input wire logic [1:0] cable_drop_comp_gain_o,
	input wire logic [1:0] fet_driver_sequencing_o,
	input wire logic [1:0] fet_driver_supply_select_o,
	input wire logic [7:0] input_threshold_code_o,
	input wire logic [15:0] input_threshold_mv_o,
	input wire logic protect_active_o,
	input wire logic regulate_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] cfg;

	// Low seven bits of the config byte
	assign cfg = {cable_drop_comp_enable_o, cable_drop_comp_gain_o, fet_driver_sequencing_o,
		fet_driver_supply_select_o};

	// Two-segment millivolt map
	function automatic logic [15:0] mv_of(input logic [7:0] c);
		return (c < 8'h95) ? 16'h128e + 16'h007d * c : 16'h5bcc + 16'h00fa * (c - 8'h95);
	endfunction : mv_of

	// ==========================================
	// Checks
	default clocking @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	// Acknowledge follows a stored byte
	sequence ack_soon;
		##[0:3] sda_oe_o;
	endsequence

	chk_pin_low: assert property (sda_o == 1'b0)
		else $error("data pin drives high");
	chk_reset_vals: assert property ($fell(srst_i) |->
		{fb_div_select_o, cfg} == 8'h8b && input_threshold_code_o == 8'hff)
		else $error("reset values");
	chk_mv_map: assert property (input_threshold_mv_o ==
		mv_of($past(input_threshold_code_o))) else $error("mv map");
	chk_cfg_write: assert property (!$stable(cfg) |-> ack_soon)
		else $error("config moved without a write");
	chk_thr_write: assert property (!$stable(input_threshold_code_o) |-> ack_soon)
		else $error("threshold moved without a write");
	chk_oe_scl_low: assert property (!$stable(sda_oe_o) |-> !scl_i && !$past(scl_i, 3))
		else $error("data changed with clock high");
	chk_sel_excl: assert property (protect_active_o != regulate_active_o)
		else $error("both or no function active");
	chk_sel_follow: assert property (!$past(srst_i) |->
		regulate_active_o == $past(input_regulation_select_i)) else $error("select lag");
endmodule : cvcfg_assertions

/* dv/cvcfg_host.sv */
// Host controller model on the serial register bus
module cvcfg_host (
	// Clock
	input wire logic mclk_i,
	// Wire level of the data line
	input wire logic sda_i,
	// Clock line and data pull-down
	output logic scl_o,
	output logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// Lines released, pull-ups hold them high
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
	end

	// Quarter bit wait
	task automatic wt;
		repeat (8) @(posedge mclk_i);
	endtask : wt

	// One bit, sampled mid clock-high
	task automatic sbit(input logic d, output logic r);
		wt();
		scl_o <= 1'b0;
		wt();
		sda_low_o <= ~d;
		wt();
		scl_o <= 1'b1;
		wt();
		r = sda_i;
	endtask : sbit

	// Start or repeated start
	task automatic start;
		wt();
		scl_o <= 1'b0;
		wt();
		sda_low_o <= 1'b0;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_low_o <= 1'b1;
		wt();
	endtask : start

	// Stop, then idle
	task automatic stop;
		wt();
		scl_o <= 1'b0;
		wt();
		sda_low_o <= 1'b1;
		wt();
		scl_o <= 1'b1;
		wt();
		sda_low_o <= 1'b0;
		wt();
	endtask : stop

	// Whole byte MSB first, then the ninth bit
	task automatic xbyte(input logic [7:0] w, input logic l, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) sbit(w[i], r[i]);
		sbit(l, a);
	endtask : xbyte
endmodule : cvcfg_host

/* dv/cvcfg_top_bench.sv */
// Bench for the converter config bank
`include "cvcfg_defs.svh"

module cvcfg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk_i = 1'b0;
	logic srst_i = 1'b1;
	logic input_regulation_select_i = 1'b0;
	logic scl_i, sda_i, sda_o, sda_oe_o, sda_low, fb_div_select_o, cable_drop_comp_enable_o;
	logic protect_active_o, regulate_active_o;
	logic [1:0] cable_drop_comp_gain_o, fet_driver_sequencing_o, fet_driver_supply_select_o;
	logic [7:0] input_threshold_code_o;
	logic [15:0] input_threshold_mv_o;
	logic [6:0] cfg;
	int errors = 0;
	int checks = 0;

	// Clock, open-drain wire and config view
	always #5 mclk_i = ~mclk_i;
	assign sda_i = !(sda_low || (sda_oe_o && !sda_o));
	assign cfg = {cable_drop_comp_enable_o, cable_drop_comp_gain_o, fet_driver_sequencing_o,
		fet_driver_supply_select_o};

	cvcfg_top u_dut (
		.mclk_i(mclk_i),
		.srst_i(srst_i),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe_o(sda_oe_o),
		.input_regulation_select_i(input_regulation_select_i),
		.fb_div_select_o(fb_div_select_o),
		.cable_drop_comp_enable_o(cable_drop_comp_enable_o),
		.cable_drop_comp_gain_o(cable_drop_comp_gain_o),
		.fet_driver_sequencing_o(fet_driver_sequencing_o),
		.fet_driver_supply_select_o(fet_driver_supply_select_o),
		.input_threshold_code_o(input_threshold_code_o),
		.input_threshold_mv_o(input_threshold_mv_o),
		.protect_active_o(protect_active_o),
		.regulate_active_o(regulate_active_o)
	);
	cvcfg_host u_host (.mclk_i, .sda_i, .scl_o(scl_i), .sda_low_o(sda_low));

	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		checks++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic [7:0] r;
		logic [2:0] a;
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR, 1'b0}, 1'b1, r, a[0]);
		u_host.xbyte(p, 1'b1, r, a[1]);
		u_host.xbyte(d, 1'b1, r, a[2]);
		u_host.stop();
		chk("write ack", 16'h0, 16'(a));
	endtask : wr

	task automatic rd(input logic [7:0] p, input logic [7:0] e);
		logic [7:0] r;
		logic [2:0] a;
		logic n;
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR, 1'b0}, 1'b1, r, a[0]);
		u_host.xbyte(p, 1'b1, r, a[1]);
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR, 1'b1}, 1'b1, r, a[2]);
		u_host.xbyte(8'hff, 1'b1, r, n);
		u_host.stop();
		chk("read ack", 16'h0, 16'(a));
		chk("master nack", 16'h1, 16'(n));
		chk("readback", 16'(e), 16'(r));
	endtask : rd

	task automatic do_reset;
		srst_i <= 1'b1;
		repeat (6) @(posedge mclk_i);
		srst_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
	endtask : do_reset

	task automatic t_reset;
		chk("cfg", 16'h0b, 16'(cfg));
		chk("thr", 16'hff, 16'(input_threshold_code_o));
		chk("mv", 16'hc350, input_threshold_mv_o);
		chk("fb", 16'h1, 16'(fb_div_select_o));
		chk("sel", 16'h2, 16'({protect_active_o, regulate_active_o}));
		rd(8'hd8, 8'h8b);
		rd(8'hda, 8'hff);
		$display("t_reset done");
	endtask : t_reset

	task automatic t_cfg;
		logic [7:0] v [4] = '{8'h5a, 8'ha5, 8'hff, 8'h00};
		foreach (v[i]) begin
			wr(8'hd8, v[i]);
			chk("cfg out", 16'(v[i][6:0]), 16'(cfg));
			chk("fb out", 16'(v[i][7]), 16'(fb_div_select_o));
			rd(8'hd8, v[i]);
		end
		$display("t_cfg done");
	endtask : t_cfg

	task automatic t_thr;
		logic [7:0] v [4] = '{8'h00, 8'h94, 8'h95, 8'hfe};
		logic [15:0] m [4] = '{16'h128e, 16'h5ad2, 16'h5bcc, 16'hc256};
		foreach (v[i]) begin
			wr(8'hda, v[i]);
			chk("thr", 16'(v[i]), 16'(input_threshold_code_o));
			chk("mv", m[i], input_threshold_mv_o);
			rd(8'hda, v[i]);
		end
		chk("cfg kept", 16'h0, 16'(cfg));
		$display("t_thr done");
	endtask : t_thr

	task automatic t_sel;
		input_regulation_select_i <= 1'b1;
		repeat (2) @(negedge mclk_i);
		chk("sel", 16'h1, 16'({protect_active_o, regulate_active_o}));
		@(posedge mclk_i);
		input_regulation_select_i <= 1'b0;
		repeat (2) @(negedge mclk_i);
		chk("sel", 16'h2, 16'({protect_active_o, regulate_active_o}));
		$display("t_sel done");
	endtask : t_sel

	task automatic t_bad;
		logic [7:0] r;
		logic a;
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
		u_host.stop();
		chk("nack", 16'h1, 16'(a));
		wr(8'hd9, 8'h3c);
		chk("cfg kept", 16'h0, 16'(cfg));
		chk("thr kept", 16'hfe, 16'(input_threshold_code_o));
		rd(8'hd9, 8'h00);
		$display("t_bad done");
	endtask : t_bad

	// Extra bytes rewrite and reread the same register
	task automatic t_multi;
		logic [7:0] r;
		logic [7:0] q;
		logic [3:0] a;
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR, 1'b0}, 1'b1, r, a[0]);
		u_host.xbyte(8'hd8, 1'b1, r, a[1]);
		u_host.xbyte(8'h33, 1'b1, r, a[2]);
		u_host.xbyte(8'hc6, 1'b1, r, a[3]);
		u_host.stop();
		chk("multi ack", 16'h0, 16'(a));
		chk("cfg multi", 16'h46, 16'(cfg));
		chk("fb multi", 16'h1, 16'(fb_div_select_o));
		u_host.start();
		u_host.xbyte({`CVCFG_I2C_ADDR, 1'b1}, 1'b1, r, a[0]);
		u_host.xbyte(8'hff, 1'b0, q, a[1]);
		u_host.xbyte(8'hff, 1'b1, r, a[2]);
		u_host.stop();
		chk("reread ack", 16'h0, 16'(a[0]));
		chk("reread first", 16'hc6, 16'(q));
		chk("reread second", 16'hc6, 16'(r));
		$display("t_multi done");
	endtask : t_multi

	task automatic close_out;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : close_out

	// Main sequence, second reset restores defaults
	initial begin
		do_reset();
		t_reset();
		t_cfg();
		t_thr();
		t_sel();
		t_bad();
		t_multi();
		do_reset();
		t_reset();
		close_out();
	end

	// Watchdog
	initial begin
		#600000;
		errors++;
		close_out();
	end
endmodule : cvcfg_top_bench

bind cvcfg_top cvcfg_assertions u_chk (
	.mclk_i(mclk_i),
	.srst_i(srst_i),
	.scl_i(scl_i),
	.sda_o(sda_o),
	.sda_oe_o(sda_oe_o),
	.input_regulation_select_i(input_regulation_select_i),
	.fb_div_select_o(fb_div_select_o),
	.cable_drop_comp_enable_o(cable_drop_comp_enable_o),
	.cable_drop_comp_gain_o(cable_drop_comp_gain_o),
	.fet_driver_sequencing_o(fet_driver_sequencing_o),
	.fet_driver_supply_select_o(fet_driver_supply_select_o),
	.input_threshold_code_o(input_threshold_code_o),
	.input_threshold_mv_o(input_threshold_mv_o),
	.protect_active_o(protect_active_o),
	.regulate_active_o(regulate_active_o)
);
